/* rtl/flash_cmd_regs.vh */
// constants for the serial flash setting command decoder
`ifndef FLASH_CMD_REGS_VH
`define FLASH_CMD_REGS_VH
// opcodes
`define OP_SET_WEL 8'h06
`define OP_CLR_WEL 8'h04
`define OP_STATUS_RD 8'h05
`define OP_STATUS_WR 8'h01
`define OP_PROT_SEL 8'h68
`define OP_QUAD_ENTER 8'h35
`define OP_QUAD_LEAVE 8'hF5
`define OP_WIDE_ENTER 8'hB7
`define OP_WIDE_LEAVE 8'hE9
`define OP_SUSPEND 8'hB0
`define OP_RESUME 8'h30
`define OP_SLEEP 8'hB9
`define OP_WAKE 8'hAB
`define OP_BURST 8'hC0
`define OP_BOOT_RD 8'h16
`define OP_BOOT_WR 8'h17
`define OP_BOOT_ERASE 8'h18
// byte counts of the data phases
`define BOOT_WR_BYTES 3'h4
// apb register byte offsets
`define REG_STATE 12'h000
`define REG_BURST 12'h004
`define REG_BOOT 12'h008
`define REG_CTRL 12'h00C
// state register fields
`define ST_WEL 0
`define ST_QUAD 1
`define ST_WIDE 2
`define ST_SUSP 3
`define ST_SLEEP 4
`define ST_PROT 5
`define ST_SR_LSB 8
`define ST_CR_LSB 16
// ctrl register fields
`define CTRL_BUSY 0
// reset values
`define BOOT_RESET 32'hFFFFFFFF
`define BURST_RESET 8'h00
`endif

/* rtl/serial_flash_setting_cmd_decoder.v */
// serial flash setting command decoder with apb status/control access
`timescale 1ns/1ps
`include "flash_cmd_regs.vh"
module serial_flash_setting_cmd_decoder (
  // apb clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // serial bus pins
  input wire sclk,
  input wire cs_n,
  input wire [3:0] io_in,
  output reg [3:0] io_out,
  output reg [3:0] io_oe_n
);

  // legal in this bus mode (quad=1 four-line)
  function cmd_mode_ok;
    input [7:0] op;
    input quad;
    begin
      case (op)
        `OP_QUAD_ENTER, `OP_BOOT_RD, `OP_BOOT_WR, `OP_BOOT_ERASE: cmd_mode_ok = ~quad;
        `OP_QUAD_LEAVE: cmd_mode_ok = quad;
        default: cmd_mode_ok = 1'b1;
      endcase
    end
  endfunction

  // pin synchronisers: stage1 is read only by stage2
  reg [5:0] pin1_q;
  reg [5:0] pin2_q;
  reg sclk3_q;
  reg cs3_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin1_q <= 6'h20;
      pin2_q <= 6'h20;
      sclk3_q <= 1'b0;
      cs3_q <= 1'b1;
    end else begin
      pin1_q <= {cs_n, sclk, io_in};
      pin2_q <= pin1_q;
      sclk3_q <= pin2_q[4];
      cs3_q <= pin2_q[5];
    end
  end
  wire [3:0] io_s = pin2_q[3:0];
  wire cs_s = pin2_q[5];
  wire rise = ~cs_s & pin2_q[4] & ~sclk3_q;
  wire fall = ~cs_s & ~pin2_q[4] & sclk3_q;
  wire frame_end = cs_s & ~cs3_q;

  // device state
  reg wel_q, quad_q, wide_q, susp_q, sleep_q, prot_q, busy_q;
  reg [7:0] sr_q, cr_q, burst_q;
  reg [31:0] boot_q;
  // frame state
  reg [7:0] shift_q, op_q, sr_new_q, cr_new_q;
  reg [2:0] bit_q, bytes_q;
  reg [31:0] boot_new_q, tx_q;
  reg rd_q;

  // shift path: one bit per edge single-line, four bits four-line
  wire [3:0] step = quad_q ? 4'h4 : 4'h1;
  wire [3:0] bit_sum = {1'b0, bit_q} + step;
  wire [7:0] shifted = quad_q ? {shift_q[3:0], io_s} : {shift_q[6:0], io_s[0]};
  wire byte_done = rise & bit_sum[3];
  wire whole = (bit_q == 3'h0);
  wire op_ok = cmd_mode_ok(op_q, quad_q) & (~sleep_q | (op_q == `OP_WAKE));
  wire plain = whole & (bytes_q == 3'h1);
  wire [7:0] status_byte = sr_q | {6'h00, wel_q, busy_q};

  // frame capture, read-out and command execution at chip select release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wel_q <= 1'b0;
      quad_q <= 1'b0;
      wide_q <= 1'b0;
      susp_q <= 1'b0;
      sleep_q <= 1'b0;
      prot_q <= 1'b0;
      sr_q <= 8'h00;
      cr_q <= 8'h00;
      burst_q <= `BURST_RESET;
      boot_q <= `BOOT_RESET;
      shift_q <= 8'h00;
      op_q <= 8'h00;
      sr_new_q <= 8'h00;
      cr_new_q <= 8'h00;
      bit_q <= 3'h0;
      bytes_q <= 3'h0;
      boot_new_q <= 32'h00000000;
      tx_q <= 32'h00000000;
      rd_q <= 1'b0;
      io_out <= 4'h0;
      io_oe_n <= 4'hF;
    end else if (frame_end) begin
      bit_q <= 3'h0;
      bytes_q <= 3'h0;
      rd_q <= 1'b0;
      io_oe_n <= 4'hF;
      if (op_ok) begin
        case (op_q)
          `OP_SET_WEL: if (plain) wel_q <= 1'b1;
          `OP_CLR_WEL: if (plain) wel_q <= 1'b0;
          `OP_PROT_SEL: if (plain) prot_q <= 1'b1;
          `OP_QUAD_ENTER: if (plain) quad_q <= 1'b1;
          `OP_QUAD_LEAVE: if (plain) quad_q <= 1'b0;
          `OP_WIDE_ENTER: if (plain) wide_q <= 1'b1;
          `OP_WIDE_LEAVE: if (plain) wide_q <= 1'b0;
          `OP_SUSPEND: if (plain & busy_q) susp_q <= 1'b1;
          `OP_RESUME: if (plain) susp_q <= 1'b0;
          `OP_SLEEP: if (plain) sleep_q <= 1'b1;
          `OP_WAKE: sleep_q <= 1'b0;
          `OP_BURST: if (whole & (bytes_q == 3'h2)) burst_q <= shift_q;
          `OP_STATUS_WR: begin
            if (whole & wel_q & (bytes_q == 3'h2 | bytes_q == 3'h3)) begin
              sr_q <= sr_new_q;
              wel_q <= 1'b0;
              if (bytes_q == 3'h3) cr_q <= cr_new_q;
            end
          end
          `OP_BOOT_WR: begin
            if (whole & wel_q & (bytes_q == `BOOT_WR_BYTES + 3'h1)) begin
              boot_q <= boot_new_q;
              wel_q <= 1'b0;
            end
          end
          `OP_BOOT_ERASE: begin
            if (plain & wel_q) begin
              boot_q <= `BOOT_RESET;
              wel_q <= 1'b0;
            end
          end
          default: ;
        endcase
      end
    end else if (rise) begin
      shift_q <= shifted;
      bit_q <= bit_sum[2:0];
      if (byte_done) begin
        // count saturates so overlong frames stay rejected
        if (bytes_q != 3'h7) bytes_q <= bytes_q + 3'h1;
        if (bytes_q == 3'h0) begin
          op_q <= shifted;
          // boot read in single-line only; status read either mode
          if (~sleep_q & ((shifted == `OP_BOOT_RD & ~quad_q) | shifted == `OP_STATUS_RD)) begin
            rd_q <= 1'b1;
            // status read repeats the status byte captured with the opcode
            tx_q <= (shifted == `OP_BOOT_RD) ? boot_q : {4{status_byte}};
          end
        end else begin
          if (bytes_q == 3'h1) sr_new_q <= shifted;
          if (bytes_q == 3'h2) cr_new_q <= shifted;
          boot_new_q <= {boot_new_q[23:0], shifted};
        end
      end
    end else if (fall & rd_q) begin
      // read data rotates so a longer read repeats the word
      if (quad_q) begin
        io_out <= tx_q[31:28];
        io_oe_n <= 4'h0;
        tx_q <= {tx_q[27:0], tx_q[31:28]};
      end else begin
        io_out <= {2'h0, tx_q[31], 1'b0};
        io_oe_n <= 4'hD;
        tx_q <= {tx_q[30:0], tx_q[31]};
      end
    end
  end

  // apb slave: one wait-free access, answer prepared in setup
  wire setup = psel & ~penable;
  wire hit = (paddr == `REG_STATE) | (paddr == `REG_BURST) | (paddr == `REG_BOOT) | (paddr == `REG_CTRL);
  reg [31:0] rd_mux;
  always @* begin
    case (paddr)
      `REG_STATE: rd_mux = {8'h00, cr_q, status_byte, 2'h0, prot_q, sleep_q, susp_q, wide_q,
        quad_q, wel_q};
      `REG_BURST: rd_mux = {24'h000000, burst_q};
      `REG_BOOT: rd_mux = boot_q;
      `REG_CTRL: rd_mux = {31'h00000000, busy_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // busy flag written by software gates suspend
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      busy_q <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      prdata <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
      if (psel & penable & pready & pwrite & (paddr == `REG_CTRL)) busy_q <= pwdata[`CTRL_BUSY];
    end
  end

endmodule // serial_flash_setting_cmd_decoder

/* dv/flash_host_model.sv */
// host-side serial controller model that frames commands
`timescale 1ns/1ps
module flash_host_model (
  // serial pins toward the device
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_in,
  input wire [3:0] io_out,
  input wire [3:0] io_oe_n
);
  logic [31:0] rx;
  // idle: clock low, select high
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io_in = 4'hA;
    rx = 32'h0;
  end
  // one frame of n bits, msb first; odd offset keeps phase unrelated
  task frame(input logic [63:0] b, input int n, input bit q);
    int i;
    #13 cs_n = 1'b0;
    for (i = n - 1; i >= 0; i = i - (q ? 4 : 1)) begin
      io_in = q ? b[i-:4] : {3'h0, b[i]};
      #200 sclk = 1'b1;
      // an undriven line reads as the inverse, so a missing enable shows
      rx = {rx[30:0], io_oe_n[1] ? ~io_out[1] : io_out[1]};
      #200 sclk = 1'b0;
    end
    #100 cs_n = 1'b1;
    // released lines show the inverse level, not a stale copy
    io_in = ~io_in;
    #600;
  endtask
endmodule // flash_host_model

/* dv/serial_flash_setting_cmd_decoder_props.sv */
// assertions on the decoder's apb and serial pins
`timescale 1ns/1ps
module flash_cmd_props (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // serial pins
  input wire sclk,
  input wire cs_n,
  input wire [3:0] io_in,
  input wire [3:0] io_out,
  input wire [3:0] io_oe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  // zero wait states, one-cycle answer
  rdy_after_setup_a: assert property (setup |=> pready) else $error("no ready");
  rdy_one_cycle_a: assert property (pready |=> !pready) else $error("ready held");
  err_with_rdy_a: assert property (pslverr |-> pready) else $error("stray error");
  err_unmapped_a: assert property (setup && paddr > 12'h00C |=> pslverr) else $error("no refusal");
  rd_idle_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("data not zero");
  rst_release_a: assert property ($rose(presetn) |-> io_oe_n == 4'hF && !pready) else $error("bad reset");
  // lines released once the frame is long over
  oe_idle_a: assert property (cs_n [*8] |-> io_oe_n == 4'hF) else $error("oe held");
  oe_legal_a: assert property (io_oe_n inside {4'hF, 4'hD, 4'h0}) else $error("bad oe");
  wel_in_status_a: assert property (pready && paddr == 12'h000 && prdata[0] |-> prdata[9])
    else $error("latch not in status");
  cover property (pslverr);
  cover property (io_oe_n == 4'hD);
  cover property (pready && paddr == 12'h000 && prdata[1]);
endmodule // flash_cmd_props
bind serial_flash_setting_cmd_decoder flash_cmd_props i_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .sclk, .cs_n, .io_in, .io_out, .io_oe_n);

/* dv/serial_flash_setting_cmd_decoder_tb_top.sv */
// self-checking bench for the setting command decoder
`timescale 1ns/1ps
`include "flash_cmd_regs.vh"
module serial_flash_setting_cmd_decoder_tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdata;
  wire [31:0] prdata;
  wire pready, pslverr, sclk, cs_n;
  wire [3:0] io_in, io_out, io_oe_n;
  int n_mismatch = 0, checks_done = 0;
  always #25 pclk = ~pclk;
  serial_flash_setting_cmd_decoder i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sclk, .cs_n, .io_in, .io_out, .io_oe_n);
  flash_host_model i_host (.sclk, .cs_n, .io_in, .io_out, .io_oe_n);
  task tally_and_finish;
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", w, e, g);
    end
  endtask
  // one apb transfer, held until ready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      n_mismatch++;
      tally_and_finish;
    end
  endtask
  task rd(input string w, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(w, e, rdata);
  endtask
  task op1(input logic [7:0] c);
    i_host.frame(c, 8, 1'b0);
  endtask
  task op4(input logic [7:0] c);
    i_host.frame(c, 8, 1'b1);
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd("state", `REG_STATE, 32'h0);
    rd("burst", `REG_BURST, 32'h0);
    rd("boot", `REG_BOOT, `BOOT_RESET);
    apb(1'b1, `REG_STATE, 32'hFFFFFFFF);
    rd("state ro", `REG_STATE, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    op1(`OP_SET_WEL);
    rd("wel set", `REG_STATE, 32'h201);
    op1(`OP_CLR_WEL);
    rd("wel clr", `REG_STATE, 32'h0);
    i_host.frame({`OP_SET_WEL, 1'b0}, 9, 1'b0);
    rd("nine bits", `REG_STATE, 32'h0);
    op1(`OP_SET_WEL);
    i_host.frame({`OP_STATUS_WR, 16'h3C5A}, 24, 1'b0);
    rd("status_config_write_cmd", `REG_STATE, 32'h5A3C00);
    op1(`OP_SET_WEL);
    i_host.frame({`OP_BOOT_WR, 32'h12345678}, 40, 1'b0);
    rd("boot wr", `REG_BOOT, 32'h12345678);
    i_host.frame({`OP_BOOT_RD, 32'h0}, 40, 1'b0);
    chk("boot rd", 32'h12345678, i_host.rx);
    op1(`OP_SET_WEL);
    op1(`OP_BOOT_ERASE);
    rd("boot erase", `REG_BOOT, 32'hFFFFFFFF);
    op1(`OP_WIDE_ENTER);
    rd("wide", `REG_STATE, 32'h5A3C04);
    op1(`OP_WIDE_LEAVE);
    i_host.frame({`OP_BURST, 8'h23}, 16, 1'b0);
    rd("burst", `REG_BURST, 32'h23);
    op1(`OP_PROT_SEL);
    rd("prot", `REG_STATE, 32'h5A3C20);
    apb(1'b1, `REG_CTRL, 32'h1);
    op1(`OP_SUSPEND);
    rd("susp", `REG_STATE, 32'h5A3D28);
    op1(`OP_RESUME);
    rd("resume", `REG_STATE, 32'h5A3D20);
    apb(1'b1, `REG_CTRL, 32'h0);
    op1(`OP_QUAD_ENTER);
    op4(`OP_SET_WEL);
    op4(`OP_BOOT_ERASE);
    rd("quad", `REG_STATE, 32'h5A3E23);
    op4(`OP_CLR_WEL);
    op4(`OP_QUAD_LEAVE);
    rd("single", `REG_STATE, 32'h5A3C20);
    op1(`OP_SLEEP);
    op1(`OP_SET_WEL);
    rd("sleep", `REG_STATE, 32'h5A3C30);
    op1(`OP_WAKE);
    rd("wake", `REG_STATE, 32'h5A3C20);
    op1(`OP_SET_WEL);
    i_host.frame({`OP_STATUS_RD, 32'h0}, 40, 1'b0);
    chk("status rd", 32'h3E3E3E3E, i_host.rx);
    i_host.frame({`OP_STATUS_WR, 8'h11}, 16, 1'b0);
    rd("status_config_write_cmd one", `REG_STATE, 32'h5A1120);
    tally_and_finish;
  end
  // hang guard
  initial begin
    #3000000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule // serial_flash_setting_cmd_decoder_tb_top
